// ---- hw/chan_led_defines.vh ----
// Register offsets, field positions, reset values and timing counts for the status/LED block.
`ifndef CHAN_LED_DEFINES_VH
`define CHAN_LED_DEFINES_VH

// ============================================================
// Register offsets (7-bit register address space)
// ============================================================
`define CHAN_B_STAT_OFS 7'h0D
`define LED_CTRL_OFS 7'h0E

// ============================================================
// Second channel status/control fields
// ============================================================
`define CB_SOFT_RESET_BIT 7
`define CB_FRAMER_EN_BIT 6
`define CB_CLIM_LATCHED_BIT 5
`define CB_UV_LATCHED_BIT 4
`define CB_FAULT_LATCHED_BIT 3
`define CB_CLIM_NOW_BIT 2
`define CB_UV_NOW_BIT 1
`define CB_FAULT_NOW_BIT 0

// ============================================================
// Indicator pin control fields
// ============================================================
`define LED_B_ERR_ON_BIT 7
`define LED_B_ERR_SEL_BIT 6
`define LED_B_RDY_ON_BIT 5
`define LED_B_RDY_SEL_BIT 4
`define LED_A_ERR_ON_BIT 3
`define LED_A_ERR_SEL_BIT 2
`define LED_A_RDY_ON_BIT 1
`define LED_A_RDY_SEL_BIT 0

// ============================================================
// Reset values
// ============================================================
`define LED_CTRL_RESET 8'h00
`define FLAGS_RESET 3'h0

// ============================================================
// Timing
// ============================================================
`define CLK_PERIOD_NS 10
// Current-limit blanking time, in ns.
`define BLANK_TIME_NS 1000
// Least time rounds up to whole cycles.
`define BLANK_CYCLES ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Cycles the channel-local reset is held.
`define SOFT_RESET_CYCLES 3'h4

// ============================================================
// Serial frame
// ============================================================
`define SPI_READ_FLAG_BIT 7
`define SPI_CMD_LAST 4'h7
`define SPI_DATA_LAST 4'hF

`endif

// ---- hw/serial_reg_port.v ----
// Serial register port slave: command byte then data byte, SPI mode 0.
`timescale 1ns/1ps
`include "chan_led_defines.vh"

module serial_reg_port (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst_n,
    // Serial pins.
    input wire i_spi_sclk,
    input wire i_spi_cs_n,
    input wire i_spi_mosi,
    output reg o_spi_miso,
    output reg o_spi_miso_oe,
    // Register side.
    output reg [6:0] o_addr,
    output reg [7:0] o_wdata,
    output reg o_wr,
    output reg o_rd,
    input wire [7:0] i_rdata
);

    // ============================================================
    // Pin synchronisers
    // ============================================================
    reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    reg cs_s1_reg, cs_s2_reg;
    reg mosi_s1_reg, mosi_s2_reg;
    reg [3:0] bit_cnt_reg;
    reg [6:0] shift_in_reg;
    reg is_read_reg;
    reg [7:0] shift_out_reg;
    wire sclk_rise;
    wire sclk_fall;

    // Only the second stage is looked at; the third gives the edge.
    assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;

    // Two flops for every pin before any logic reads it.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= i_spi_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            cs_s1_reg <= i_spi_cs_n;
            cs_s2_reg <= cs_s1_reg;
            mosi_s1_reg <= i_spi_mosi;
            mosi_s2_reg <= mosi_s1_reg;
        end
    end

    // ============================================================
    // Frame engine
    // ============================================================
    // The read strobe and the capture of read data share one edge, so a
    // clear-on-read register is captured before it clears.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt_reg <= 4'h0;
            shift_in_reg <= 7'h00;
            is_read_reg <= 1'b0;
            shift_out_reg <= 8'h00;
            o_addr <= 7'h00;
            o_wdata <= 8'h00;
            o_wr <= 1'b0;
            o_rd <= 1'b0;
            o_spi_miso <= 1'b0;
            o_spi_miso_oe <= 1'b0;
        end else begin
            o_wr <= 1'b0;
            o_rd <= 1'b0;
            o_spi_miso_oe <= ~cs_s2_reg;
            if (o_rd) begin
                shift_out_reg <= i_rdata;
            end
            if (cs_s2_reg) begin
                bit_cnt_reg <= 4'h0;
                is_read_reg <= 1'b0;
                o_spi_miso <= 1'b0;
            end else if (sclk_rise) begin
                shift_in_reg <= {shift_in_reg[5:0], mosi_s2_reg};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == `SPI_CMD_LAST) begin
                    o_addr <= {shift_in_reg[5:0], mosi_s2_reg};
                    is_read_reg <= shift_in_reg[6];
                    o_rd <= shift_in_reg[6];
                end else if (bit_cnt_reg == `SPI_DATA_LAST) begin
                    o_wdata <= {shift_in_reg, mosi_s2_reg};
                    o_wr <= ~is_read_reg;
                end
            end else if (sclk_fall && is_read_reg && bit_cnt_reg[3]) begin
                // Data byte of a read goes out MSB first on falling edges.
                o_spi_miso <= shift_out_reg[7];
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            end
        end
    end

endmodule // serial_reg_port

// ---- hw/edge_latch_flags.v ----
// Three clear-on-read flags that latch rising edges of real-time bits.
`timescale 1ns/1ps
`include "chan_led_defines.vh"

module edge_latch_flags (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst_n,
    // Channel-local reset, register read clear.
    input wire i_chan_reset,
    input wire i_read_clear,
    // Real-time bits and their latched copies.
    input wire [2:0] i_now,
    output reg [2:0] o_latched
);

    reg [2:0] prev_reg;
    wire [2:0] rise;

    // Only a zero-to-one change sets a flag, never a standing level.
    assign rise = i_now & ~prev_reg;

    // ============================================================
    // Latches
    // ============================================================
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_reg <= `FLAGS_RESET;
            o_latched <= `FLAGS_RESET;
        end else if (i_chan_reset) begin
            prev_reg <= `FLAGS_RESET;
            o_latched <= `FLAGS_RESET;
        end else begin
            prev_reg <= i_now;
            o_latched <= rise | (o_latched & {3{~i_read_clear}});
        end
    end

endmodule // edge_latch_flags

// ---- hw/channel_status_led_pin_control.v ----
// Second channel status/control register and shared indicator pin control register.
//
// How it works
// - reset bit clears channel-two state, FIFOs.
// - reset bit self-clears when reset completes.
// - framer enable turns on UART, handler, FIFOs.
// - current-limit latch sets on rise, read-clears.
// - undervoltage latch sets on rise, read-clears.
// - driver fault latch sets on rise, read-clears.
// - current-limit bit after blanking, clears when retry ends.
// - undervoltage bit with threshold hysteresis.
// - driver fault bit follows fault, not read-cleared.
// - channel-two error LED when select zero.
// - error select shows receive error on pin.
// - error pin ignores receive-error interrupt mask.
// - channel-two ready LED when select zero.
// - ready select shows data-ready, mask ignored.
// - channel-one error LED when select zero.
// - channel-one error select shows receive error.
// - channel-one ready LED when select zero.
`timescale 1ns/1ps
`include "chan_led_defines.vh"

module channel_status_led_pin_control (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst_n,
    // Serial register port.
    input wire i_spi_sclk,
    input wire i_spi_cs_n,
    input wire i_spi_mosi,
    output wire o_spi_miso,
    output wire o_spi_miso_oe,
    // Second channel supply and driver monitors (asynchronous).
    input wire i_supply_over_limit,
    input wire i_supply_retry_active,
    input wire i_supply_below_fall_thresh,
    input wire i_supply_above_rise_thresh,
    input wire i_line_driver_fault,
    // Receive status from the framers (same clock).
    input wire i_first_channel_receive_error_status,
    input wire i_first_channel_receive_data_ready_status,
    input wire i_second_channel_receive_error_status,
    input wire i_second_channel_receive_data_ready_status,
    // Second channel control outputs.
    output reg o_second_channel_framer_enable,
    output reg o_second_channel_reset,
    output reg o_status_interrupt,
    // Indicator pins, high means pin asserted or LED on.
    output reg o_first_channel_ready_led_pin,
    output reg o_first_channel_error_led_pin,
    output reg o_second_channel_ready_led_pin,
    output reg o_second_channel_error_led_pin
);

    // ============================================================
    // Declarations
    // ============================================================
    wire [6:0] bus_addr;
    wire [7:0] bus_wdata;
    wire bus_wr;
    wire bus_rd;
    reg [7:0] bus_rdata;
    reg [7:0] led_ctrl_reg;
    reg framer_en_reg;
    reg [2:0] reset_cnt_reg;
    reg [2:0] reset_cnt_next;
    reg clim_now_reg;
    reg uv_now_reg;
    reg fault_now_reg;
    reg [15:0] blank_cnt_reg;
    reg [4:0] mon_s1_reg;
    reg [4:0] mon_s2_reg;
    wire [2:0] latched;
    wire chan_reset;
    wire stat_read;
    wire over_limit;
    wire retry_active;
    wire below_fall;
    wire above_rise;
    wire driver_fault;

    // Reset of the channel is in progress while the counter runs.
    assign chan_reset = (reset_cnt_reg != 3'h0);
    assign stat_read = bus_rd &&
        (bus_addr == `CHAN_B_STAT_OFS);
    assign over_limit = mon_s2_reg[0];
    assign retry_active = mon_s2_reg[1];
    assign below_fall = mon_s2_reg[2];
    assign above_rise = mon_s2_reg[3];
    assign driver_fault = mon_s2_reg[4];

    // Drive one indicator pin: status in signalling mode, else LED bit.
    function pin_level;
        input sel;
        input led_on;
        input status;
        begin
            pin_level = sel ? status : led_on;
        end
    endfunction

    // ============================================================
    // Register port
    // ============================================================
    serial_reg_port u_port (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_spi_sclk(i_spi_sclk),
        .i_spi_cs_n(i_spi_cs_n),
        .i_spi_mosi(i_spi_mosi),
        .o_spi_miso(o_spi_miso),
        .o_spi_miso_oe(o_spi_miso_oe),
        .o_addr(bus_addr),
        .o_wdata(bus_wdata),
        .o_wr(bus_wr),
        .o_rd(bus_rd),
        .i_rdata(bus_rdata)
    );

    // Read mux; unmapped addresses read as zero.
    always @* begin
        bus_rdata = 8'h00;
        if (bus_addr == `CHAN_B_STAT_OFS) begin
            bus_rdata = {chan_reset, framer_en_reg, latched,
                         clim_now_reg, uv_now_reg, fault_now_reg};
        end else if (bus_addr == `LED_CTRL_OFS) begin
            bus_rdata = led_ctrl_reg;
        end
    end

    // ============================================================
    // Monitor synchronisers
    // ============================================================
    // Monitor comparators are asynchronous to this clock.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mon_s1_reg <= 5'h00;
            mon_s2_reg <= 5'h00;
        end else begin
            mon_s1_reg <= {i_line_driver_fault, i_supply_above_rise_thresh,
                           i_supply_below_fall_thresh, i_supply_retry_active,
                           i_supply_over_limit};
            mon_s2_reg <= mon_s1_reg;
        end
    end

    // ============================================================
    // Channel-local soft reset
    // ============================================================
    // start channel reset.
    always @* begin
        reset_cnt_next = reset_cnt_reg;
        if (chan_reset) begin
            // self-clearing countdown.
            // A second write meanwhile is ignored.
            reset_cnt_next = reset_cnt_reg - 3'h1;
        end else if (bus_wr && bus_addr == `CHAN_B_STAT_OFS &&
                     bus_wdata[`CB_SOFT_RESET_BIT]) begin
            reset_cnt_next = `SOFT_RESET_CYCLES;
        end
    end

    // The pulse also resets both second-channel FIFOs outside this block.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reset_cnt_reg <= 3'h0;
            o_second_channel_reset <= 1'b0;
        end else begin
            reset_cnt_reg <= reset_cnt_next;
            o_second_channel_reset <= (reset_cnt_next != 3'h0);
        end
    end

    // ============================================================
    // Framer enable
    // ============================================================
    // framer enable bit.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            framer_en_reg <= 1'b0;
            o_second_channel_framer_enable <= 1'b0;
        end else begin
            if (chan_reset) begin
                framer_en_reg <= 1'b0;
            end else if (bus_wr &&
                    bus_addr == `CHAN_B_STAT_OFS) begin
                framer_en_reg <= bus_wdata[`CB_FRAMER_EN_BIT];
            end
            // Drops with the reset pulse.
            o_second_channel_framer_enable <= framer_en_reg &
                (reset_cnt_next == 3'h0);
        end
    end

    // ============================================================
    // Real-time status bits
    // ============================================================
    // Reads never touch these; only the monitors and the channel reset do.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clim_now_reg <= 1'b0;
            uv_now_reg <= 1'b0;
            fault_now_reg <= 1'b0;
            blank_cnt_reg <= 16'h0000;
        end else if (chan_reset) begin
            clim_now_reg <= 1'b0;
            uv_now_reg <= 1'b0;
            fault_now_reg <= 1'b0;
            blank_cnt_reg <= 16'h0000;
        end else begin
            if (!over_limit) begin
                blank_cnt_reg <= 16'h0000;
            end else if (blank_cnt_reg != 16'hFFFF) begin
                blank_cnt_reg <= blank_cnt_reg + 16'h0001;
            end
            if (over_limit &&
                    blank_cnt_reg >= `BLANK_CYCLES) begin
                clim_now_reg <= 1'b1;
            end else if (clim_now_reg && !retry_active) begin
                clim_now_reg <= 1'b0;
            end
            // hysteresis between thresholds.
            // Below wins if both are seen.
            if (below_fall) begin
                uv_now_reg <= 1'b1;
            end else if (above_rise) begin
                uv_now_reg <= 1'b0;
            end
            fault_now_reg <= driver_fault;
        end
    end

    // ============================================================
    // Latched flags
    // ============================================================
    // edge latches.
    // A status read clears them.
    edge_latch_flags u_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_chan_reset(chan_reset),
        .i_read_clear(stat_read),
        .i_now({clim_now_reg, uv_now_reg, fault_now_reg}),
        .o_latched(latched)
    );

    // Any latched flag raises the status interrupt.
    // Masks live outside this block.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_status_interrupt <= 1'b0;
        end else begin
            o_status_interrupt <= |latched;
        end
    end

    // ============================================================
    // Indicator pin control
    // ============================================================
    // Global register: the channel reset leaves it alone.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            led_ctrl_reg <= `LED_CTRL_RESET;
        end else if (bus_wr &&
                bus_addr == `LED_CTRL_OFS) begin
            led_ctrl_reg <= bus_wdata;
        end
    end

    // Pins are registered, so they lag register and status by one cycle.
    // No interrupt mask enters here, by design of signalling mode.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_first_channel_ready_led_pin <= 1'b0;
            o_first_channel_error_led_pin <= 1'b0;
            o_second_channel_ready_led_pin <= 1'b0;
            o_second_channel_error_led_pin <= 1'b0;
        end else begin
            o_second_channel_error_led_pin <= pin_level(
                led_ctrl_reg[`LED_B_ERR_SEL_BIT], led_ctrl_reg[`LED_B_ERR_ON_BIT],
                i_second_channel_receive_error_status);
            o_second_channel_ready_led_pin <= pin_level(
                led_ctrl_reg[`LED_B_RDY_SEL_BIT], led_ctrl_reg[`LED_B_RDY_ON_BIT],
                i_second_channel_receive_data_ready_status);
            o_first_channel_error_led_pin <= pin_level(
                led_ctrl_reg[`LED_A_ERR_SEL_BIT], led_ctrl_reg[`LED_A_ERR_ON_BIT],
                i_first_channel_receive_error_status);
            o_first_channel_ready_led_pin <= pin_level(
                led_ctrl_reg[`LED_A_RDY_SEL_BIT], led_ctrl_reg[`LED_A_RDY_ON_BIT],
                i_first_channel_receive_data_ready_status);
        end
    end

endmodule // channel_status_led_pin_control

// ---- tb/status_led_checker.sv ----
// Port-level assertions for the channel status and indicator pin block.
`timescale 1ns/1ps
module status_led_checker (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst_n,
    // Watched inputs.
    input wire i_spi_cs_n,
    input wire i_supply_over_limit,
    input wire i_supply_below_fall_thresh,
    input wire i_line_driver_fault,
    // Watched outputs.
    input wire o_spi_miso_oe,
    input wire o_second_channel_framer_enable,
    input wire o_second_channel_reset,
    input wire o_status_interrupt
);
    // ============================================================
    // Helper logic
    // ============================================================
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] clim_cnt;
    // Consecutive over-limit cycles, saturating.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clim_cnt <= 8'h00;
        end else if (!i_supply_over_limit) begin
            clim_cnt <= 8'h00;
        end else if (clim_cnt != 8'hFF) begin
            clim_cnt <= clim_cnt + 8'h01;
        end
    end
    // ============================================================
    // Assertions
    // ============================================================
    a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_status_interrupt && !o_second_channel_reset
        && !o_second_channel_framer_enable) else $error("outputs not idle after reset");
    a_soft_reset_len: assert property ($rose(o_second_channel_reset) |->
        o_second_channel_reset[*4] ##1 !o_second_channel_reset) else $error("soft reset length");
    a_framer_held_off: assert property (o_second_channel_reset |->
        !o_second_channel_framer_enable) else $error("framer on during soft reset");
    a_framer_stays_cleared: assert property ($fell(o_second_channel_reset) |->
        !o_second_channel_framer_enable[*2]) else $error("framer on after soft reset");
    a_fault_raises_irq: assert property ($rose(i_line_driver_fault) && !o_second_channel_reset
        |-> ##[1:8] o_status_interrupt) else $error("fault did not raise interrupt");
    a_uv_raises_irq: assert property ($rose(i_supply_below_fall_thresh) &&
        !o_second_channel_reset |-> ##[1:8] o_status_interrupt) else $error("undervoltage irq");
    a_clim_blanking: assert property ($rose(o_status_interrupt) |-> clim_cnt >= 8'h64
        || i_line_driver_fault || i_supply_below_fall_thresh) else $error("limit before blanking");
    a_oe_off: assert property (i_spi_cs_n[*5] |-> !o_spi_miso_oe) else $error("miso driven idle");
    a_oe_on: assert property (!i_spi_cs_n[*5] |-> o_spi_miso_oe) else $error("miso not driven");
    c_soft_reset: cover property ($rose(o_second_channel_reset));
    c_irq_rise: cover property ($rose(o_status_interrupt));
    c_irq_clear: cover property ($fell(o_status_interrupt));
endmodule // status_led_checker

bind channel_status_led_pin_control status_led_checker u_chk (.i_ref_clk, .i_rst_n, .i_spi_cs_n,
    .i_supply_over_limit, .i_supply_below_fall_thresh, .i_line_driver_fault, .o_spi_miso_oe,
    .o_second_channel_framer_enable, .o_second_channel_reset, .o_status_interrupt);

// ---- tb/spi_host_model.sv ----
// Host controller model that drives the serial register port.
`timescale 1ns/1ps
module spi_host_model (
    // Clock.
    input wire i_ref_clk,
    // Serial pins.
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire i_miso
);
    // ============================================================
    // Frame driver
    // ============================================================
    // Idle: clock low and deselected.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Command byte then data byte, MSB first, 10-clock half periods.
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] bits;
        bits = {cmd, wd};
        rd = 8'h00;
        wait_clk(1);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_mosi = bits[i];
            wait_clk(10);
            o_sclk = 1'b1;
            if (i < 8) rd[i] = i_miso;
            wait_clk(10);
            o_sclk = 1'b0;
        end
        wait_clk(10);
        o_cs_n = 1'b1;
        // A released data line must not keep showing the last bit.
        o_mosi = ~o_mosi;
        wait_clk(6);
    endtask
endmodule // spi_host_model

// ---- tb/channel_status_led_pin_control_tb.sv ----
// Self-checking bench for the channel status and indicator pin block.
`timescale 1ns/1ps
`include "chan_led_defines.vh"
module channel_status_led_pin_control_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic over_lim = 1'b0;
    logic retry = 1'b0;
    logic below_fall = 1'b0;
    logic above_rise = 1'b0;
    logic drv_fault = 1'b0;
    logic [3:0] sts = 4'h0;
    logic rst_seen = 1'b0;
    wire sclk, cs_n, mosi, miso, miso_oe, framer_en, chan_rst, irq;
    wire [3:0] pins;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] vals [4] = '{8'h00, 8'hAA, 8'h55, 8'h96};
    // ============================================================
    // Clock, instances and monitors
    // ============================================================
    always #5 ref_clk = ~ref_clk;
    // The soft reset pulse ends before wr returns.
    always @(posedge ref_clk) if (chan_rst) rst_seen <= 1'b1;
    spi_host_model u_host (.i_ref_clk(ref_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(miso));
    channel_status_led_pin_control u_dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
        .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
        .o_spi_miso_oe(miso_oe), .i_supply_over_limit(over_lim), .i_supply_retry_active(retry),
        .i_supply_below_fall_thresh(below_fall), .i_supply_above_rise_thresh(above_rise),
        .i_line_driver_fault(drv_fault), .i_first_channel_receive_error_status(sts[1]),
        .i_first_channel_receive_data_ready_status(sts[0]),
        .i_second_channel_receive_error_status(sts[3]),
        .i_second_channel_receive_data_ready_status(sts[2]),
        .o_second_channel_framer_enable(framer_en), .o_second_channel_reset(chan_rst),
        .o_status_interrupt(irq), .o_first_channel_ready_led_pin(pins[0]),
        .o_first_channel_error_led_pin(pins[1]), .o_second_channel_ready_led_pin(pins[2]),
        .o_second_channel_error_led_pin(pins[3]));
    // ============================================================
    // Tasks
    // ============================================================
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.frame({1'b0, a}, d, r);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        u_host.frame({1'b1, a}, 8'h00, r);
        chk8(r, exp);
    endtask
    // Each pin shows its status when selected, else its LED bit.
    function automatic logic [3:0] exp_pins(input logic [7:0] c, input logic [3:0] s);
        for (int k = 0; k < 4; k++) exp_pins[k] = c[2*k] ? s[k] : c[2*k+1];
    endfunction
    task automatic results;
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ============================================================
    // Tests
    // ============================================================
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        results();
    end
    initial begin
        step(6);
        rst_n = 1'b1;
        step(4);
        rdc(`LED_CTRL_OFS, `LED_CTRL_RESET);
        rdc(`CHAN_B_STAT_OFS, 8'h00);
        wr(7'h20, 8'hFF);
        rdc(7'h20, 8'h00);
        $display("test reset_and_unmapped done");
        for (int i = 0; i < 4; i++) begin
            wr(`LED_CTRL_OFS, vals[i]);
            rdc(`LED_CTRL_OFS, vals[i]);
            for (int j = 0; j < 4; j++) begin
                sts = vals[j][3:0];
                step(3);
                chk8({4'h0, pins}, {4'h0, exp_pins(vals[i], sts)});
            end
        end
        $display("test indicator_pins done");
        wr(`CHAN_B_STAT_OFS, 8'h40);
        chk1(framer_en, 1'b1);
        rdc(`CHAN_B_STAT_OFS, 8'h40);
        wr(`CHAN_B_STAT_OFS, 8'h00);
        chk1(framer_en, 1'b0);
        $display("test framer_enable done");
        drv_fault = 1'b1;
        step(10);
        chk1(irq, 1'b1);
        rdc(`CHAN_B_STAT_OFS, 8'h09);
        rdc(`CHAN_B_STAT_OFS, 8'h01);
        chk1(irq, 1'b0);
        drv_fault = 1'b0;
        step(10);
        rdc(`CHAN_B_STAT_OFS, 8'h00);
        below_fall = 1'b1;
        step(10);
        below_fall = 1'b0;
        step(10);
        rdc(`CHAN_B_STAT_OFS, 8'h12);
        rdc(`CHAN_B_STAT_OFS, 8'h02);
        above_rise = 1'b1;
        step(10);
        above_rise = 1'b0;
        rdc(`CHAN_B_STAT_OFS, 8'h00);
        $display("test fault_and_undervoltage done");
        over_lim = 1'b1;
        retry = 1'b1;
        step(90);
        chk1(irq, 1'b0);
        step(30);
        chk1(irq, 1'b1);
        rdc(`CHAN_B_STAT_OFS, 8'h24);
        over_lim = 1'b0;
        step(10);
        rdc(`CHAN_B_STAT_OFS, 8'h04);
        retry = 1'b0;
        step(10);
        rdc(`CHAN_B_STAT_OFS, 8'h00);
        $display("test current_limit done");
        wr(`CHAN_B_STAT_OFS, 8'h40);
        drv_fault = 1'b1;
        step(10);
        drv_fault = 1'b0;
        step(10);
        chk1(irq, 1'b1);
        wr(`CHAN_B_STAT_OFS, 8'h80);
        chk1(rst_seen, 1'b1);
        chk1(framer_en, 1'b0);
        chk1(irq, 1'b0);
        rdc(`CHAN_B_STAT_OFS, 8'h00);
        rdc(`LED_CTRL_OFS, 8'h96);
        $display("test soft_reset done");
        results();
    end
endmodule // channel_status_led_pin_control_tb
